// ===== logic/rrs_pkg.sv
// Shared constants and carrier types for the return, rotate and sleep unit.
// Assumes a 14-bit instruction word and an 8-bit data path.
package rrs_pkg;

  // ==========================================================
  // Opcode selection
  // ==========================================================
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_RET_LIT = 3'h1;
  localparam logic [2:0] OP_RETURN = 3'h2;
  localparam logic [2:0] OP_ROTATE = 3'h3;
  localparam logic [2:0] OP_SLEEP = 3'h4;

  // ==========================================================
  // Field layout and reset values
  // ==========================================================
  localparam int DEST_BIT = 7;
  localparam int FILE_ADDR_W = 7;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] WDT_CLEAR = 8'h00;
  localparam int RET_CYCLES = 2;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic FLAG_RESET = 1'b1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RET2 = 2'b01,
    ST_ASLEEP = 2'b10
  } state_t;

  typedef struct packed {
    logic [2:0] op;
    logic [7:0] literal;
    logic [6:0] file_addr;
    logic dest_file;
  } instr_t;

  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] data;
  } file_wr_t;

  typedef struct packed {
    state_t state;
    logic [7:0] acc;
    logic carry;
    logic sleep_entry_flag;
    logic expiry_flag;
    logic pop;
    logic pc_load;
    logic wdt_clear;
    logic osc_stop;
    logic busy;
    logic done;
    file_wr_t fw;
    logic [12:0] pc;
  } core_t;

endpackage

// ===== logic/return_rotate_sleep_ops.sv
// Execution unit for return-with-literal, return, rotate-left and sleep.
// Assumes the core presents one decoded instruction per issue strobe, and
// supplies the stack top entry and the addressed file register value.
//
// Summary of operation
// RULE1: Return-with-literal loads its 8-bit literal into the accumulator.
// RULE2: Return-with-literal pops the stack and loads the PC from its top.
// RULE3: Return-with-literal is one word, two cycles, and changes no flag.
// RULE4: Return pops the stack, loads the PC, takes two cycles, no flags.
// RULE5: Rotate-left shifts the file left, carry into bit 0, bit 7 out.
// RULE6: Rotate-left writes the accumulator if d is 0, else the file.
// RULE7: Sleep clears the sleep entry flag and sets the expiry flag.
// RULE8: Sleep clears the watchdog counter and its prescaler.
// RULE9: Sleep then halts the oscillator and suspends execution.
`timescale 1ns/1ps

module return_rotate_sleep_ops
  import rrs_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic issue,
  input wire instr_t instr,
  input wire logic [12:0] stack_top_entry,
  input wire logic [7:0] file_rdata,
  input wire logic wake,
  output logic [7:0] acc,
  output logic carry,
  output logic sleep_entry_flag,
  output logic expiry_flag,
  output logic stack_pop,
  output logic pc_load,
  output logic [12:0] pc_value,
  output logic watchdog_clear,
  output logic osc_stop,
  output logic busy,
  output logic done,
  output file_wr_t file_wr
);

  core_t q, d;
  logic [7:0] rot;

  assign rot = {file_rdata[6:0], q.carry}; // [RULE5]

  // ==========================================================
  // Next-state logic
  // ==========================================================
  always_comb begin
    d = q;
    d.pop = 1'b0;
    d.pc_load = 1'b0;
    d.wdt_clear = 1'b0;
    d.done = 1'b0;
    d.fw.we = 1'b0;
    case (q.state)
      ST_IDLE: begin
        if (issue) begin
          case (instr.op)
            OP_RET_LIT: begin
              d.acc = instr.literal; // [RULE1]
              d.pop = 1'b1; // [RULE2]
              d.pc_load = 1'b1;
              d.pc = stack_top_entry; // [RULE2]
              d.busy = 1'b1; // [RULE3]
              d.state = ST_RET2;
            end
            OP_RETURN: begin
              d.pop = 1'b1; // [RULE4]
              d.pc_load = 1'b1;
              d.pc = stack_top_entry; // [RULE4]
              d.busy = 1'b1;
              d.state = ST_RET2;
            end
            OP_ROTATE: begin
              d.carry = file_rdata[7]; // [RULE5]
              if (instr.dest_file) begin // [RULE6]
                d.fw.we = 1'b1;
                d.fw.addr = instr.file_addr;
                d.fw.data = rot;
              end else begin
                d.acc = rot;
              end
              d.done = 1'b1;
            end
            OP_SLEEP: begin
              d.sleep_entry_flag = 1'b0; // [RULE7]
              d.expiry_flag = 1'b1;
              d.wdt_clear = 1'b1; // [RULE8]
              d.osc_stop = 1'b1; // [RULE9]
              d.busy = 1'b1;
              d.state = ST_ASLEEP;
            end
            default: d.done = 1'b0;
          endcase
        end
      end
      ST_RET2: begin
        // Second cycle of a return: the fetched word is discarded.
        d.busy = 1'b0; // [RULE3]
        d.done = 1'b1;
        d.state = ST_IDLE;
      end
      ST_ASLEEP: begin
        // Wake handling belongs to the core; this unit only releases.
        if (wake) begin
          d.osc_stop = 1'b0;
          d.busy = 1'b0;
          d.done = 1'b1;
          d.state = ST_IDLE;
        end
      end
      default: d.state = ST_IDLE;
    endcase
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '{state: ST_IDLE, acc: ACC_RESET, carry: 1'b0,
             sleep_entry_flag: FLAG_RESET, expiry_flag: FLAG_RESET,
             pop: 1'b0, pc_load: 1'b0, wdt_clear: 1'b0, osc_stop: 1'b0,
             busy: 1'b0, done: 1'b0, fw: '0, pc: PC_RESET};
    end else begin
      q <= d;
    end
  end

  assign acc = q.acc;
  assign carry = q.carry;
  assign sleep_entry_flag = q.sleep_entry_flag;
  assign expiry_flag = q.expiry_flag;
  assign stack_pop = q.pop;
  assign pc_load = q.pc_load;
  assign pc_value = q.pc;
  assign watchdog_clear = q.wdt_clear;
  assign osc_stop = q.osc_stop;
  assign busy = q.busy;
  assign done = q.done;
  assign file_wr = q.fw;

  // ==========================================================
  // Checks
  // ==========================================================
  a_retlit_acc_load: assert property ( // [RULE1]
    @(posedge clk) disable iff (!arst_n)
    issue && !busy && instr.op == OP_RET_LIT |=>
    acc == $past(instr.literal))
    else $error("literal not loaded");
  a_retlit_pops: assert property ( // [RULE2]
    @(posedge clk) disable iff (!arst_n)
    issue && !busy && instr.op == OP_RET_LIT |=> stack_pop && pc_load &&
    pc_value == $past(stack_top_entry))
    else $error("return did not pop");
  a_retlit_two_cyc: assert property ( // [RULE3]
    @(posedge clk) disable iff (!arst_n)
    issue && !busy && instr.op == OP_RET_LIT |=> busy ##1 done && !busy)
    else $error("return length wrong");
  a_retlit_flags: assert property ( // [RULE3]
    @(posedge clk) disable iff (!arst_n)
    issue && !busy && instr.op == OP_RET_LIT |=> $stable(carry) &&
    $stable(sleep_entry_flag) && $stable(expiry_flag))
    else $error("return changed a flag");
  // A request seen in the second return cycle is dropped, not queued,
  // so the core must hold it back until busy falls.
  a_ret_second_cyc: assert property ( // [RULE3]
    @(posedge clk) disable iff (!arst_n)
    busy && !osc_stop |=> !busy && done && !stack_pop && !pc_load)
    else $error("return second cycle wrong");
  a_ret_flags_kept: assert property ( // [RULE4]
    @(posedge clk) disable iff (!arst_n)
    issue && !busy && instr.op == OP_RETURN |=> $stable(carry) &&
    $stable(acc) && stack_pop ##1 done)
    else $error("return changed state");
  a_ret_pc_load: assert property ( // [RULE4]
    @(posedge clk) disable iff (!arst_n)
    issue && !busy && instr.op == OP_RETURN |=> pc_load &&
    pc_value == $past(stack_top_entry) ##1 !busy)
    else $error("return address wrong");
  a_rotate_carry: assert property ( // [RULE5]
    @(posedge clk) disable iff (!arst_n)
    issue && !busy && instr.op == OP_ROTATE |=>
    carry == $past(file_rdata[7]))
    else $error("carry wrong");
  a_rotate_flags: assert property ( // [RULE5]
    @(posedge clk) disable iff (!arst_n)
    issue && !busy && instr.op == OP_ROTATE |=> done && !busy &&
    $stable(sleep_entry_flag) && $stable(expiry_flag))
    else $error("rotate changed a flag");
  a_rotate_dest: assert property ( // [RULE6]
    @(posedge clk) disable iff (!arst_n)
    issue && !busy && instr.op == OP_ROTATE && instr.dest_file |=>
    file_wr.we && file_wr.data == {$past(file_rdata[6:0]), $past(carry)})
    else $error("rotate dest wrong");
  a_rotate_acc: assert property ( // [RULE6]
    @(posedge clk) disable iff (!arst_n)
    issue && !busy && instr.op == OP_ROTATE && !instr.dest_file |=>
    !file_wr.we && acc == {$past(file_rdata[6:0]), $past(carry)})
    else $error("rotate acc wrong");
  a_sleep_flags: assert property ( // [RULE7]
    @(posedge clk) disable iff (!arst_n)
    issue && !busy && instr.op == OP_SLEEP |=>
    !sleep_entry_flag && expiry_flag)
    else $error("sleep flags wrong");
  a_sleep_wdt: assert property ( // [RULE8]
    @(posedge clk) disable iff (!arst_n)
    issue && !busy && instr.op == OP_SLEEP |=> watchdog_clear ##1
    !watchdog_clear)
    else $error("watchdog not cleared");
  a_sleep_stop: assert property ( // [RULE9]
    @(posedge clk) disable iff (!arst_n)
    issue && !busy && instr.op == OP_SLEEP |=> osc_stop && busy)
    else $error("sleep not entered");
  a_sleep_halt: assert property ( // [RULE9]
    @(posedge clk) disable iff (!arst_n)
    osc_stop && !wake |=> osc_stop && busy)
    else $error("sleep left early");
  // While the oscillator is stopped nothing may reach the stack or files.
  a_asleep_idle: assert property ( // [RULE9]
    @(posedge clk) disable iff (!arst_n)
    osc_stop |=> !stack_pop && !pc_load && !file_wr.we)
    else $error("activity while asleep");

endmodule

// ===== tb/return_rotate_sleep_ops_test.sv
// Random and corner-case bench for the return, rotate and sleep unit.
// Assumes the unit's registered answers follow the hand-over timing.
`timescale 1ns/1ps

module return_rotate_sleep_ops_test;
  import rrs_pkg::*;
  logic clk, arst_n, issue, wake, carry, sef, exf, pop, pcl, wdc, osc;
  logic busy, done, cm, dsel;
  instr_t instr;
  logic [12:0] top, pcv, t;
  logic [7:0] frd, acc, am, k, fd;
  logic [6:0] fa;
  logic [2:0] op;
  logic [8:0] r;
  file_wr_t fw;
  int seed = 24;
  int bad_count = 0;
  int compares = 0;

  return_rotate_sleep_ops return_rotate_sleep_ops_i (.clk(clk),
    .arst_n(arst_n), .issue(issue), .instr(instr),
    .stack_top_entry(top), .file_rdata(frd), .wake(wake), .acc(acc),
    .carry(carry), .sleep_entry_flag(sef), .expiry_flag(exf),
    .stack_pop(pop), .pc_load(pcl), .pc_value(pcv),
    .watchdog_clear(wdc), .osc_stop(osc), .busy(busy), .done(done),
    .file_wr(fw));

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [8:0] rotl(logic [7:0] v, logic c);
    return {v, c};
  endfunction

  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Operands change after the issue edge, so late sampling shows up.
  task automatic do_op();
    @(posedge clk);
    issue <= 1'b1;
    instr <= '{op, k, fa, dsel};
    frd <= fd;
    top <= t;
    @(posedge clk);
    issue <= 1'b0;
    frd <= ~fd;
    top <= ~t;
    #1;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    {arst_n, issue, wake, frd, top, dsel} = '0;
    instr = '0;
    am = ACC_RESET;
    cm = 1'b0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      op = 3'h1 + 3'($unsigned($random(seed)) % 3);
      k = (n == 0) ? 8'hFF : 8'($random(seed));
      fd = (n < 3) ? 8'h80 : 8'($random(seed));
      fa = (n == 1) ? 7'h7F : 7'($random(seed));
      dsel = 1'($random(seed));
      t = 13'($random(seed));
      do_op();
      chk("sef", sef, 1'b1);
      chk("exf", exf, 1'b1);
      if (op == OP_ROTATE) begin
        r = rotl(fd, cm);
        cm = r[8];
        if (!dsel) am = r[7:0];
        chk("carry", carry, cm);
        chk("acc", acc, am);
        chk("we", fw.we, dsel);
        if (dsel) chk("fw", {fw.addr, fw.data}, {fa, r[7:0]});
        chk("done", done, 1'b1);
      end else begin
        if (op == OP_RET_LIT) am = k;
        chk("acc", acc, am);
        chk("pop", {pop, pcl, busy}, 3'h7);
        chk("pc", pcv, t);
        chk("carry", carry, cm);
        @(posedge clk);
        #1;
        chk("end", {done, busy, pop, pcl}, 4'h8);
      end
      $display("test %0d op %0d done", n, op);
    end
    op = OP_SLEEP;
    do_op();
    chk("flags", {sef, exf, wdc, osc, busy}, 5'h0F);
    repeat (5) @(posedge clk);
    #1;
    chk("halt", {osc, busy, done, wdc}, 4'hC);
    @(posedge clk);
    wake <= 1'b1;
    for (int w = 0; w < 8 && done !== 1'b1; w++) begin
      @(posedge clk);
      #1;
    end
    chk("wake", {done, osc, busy}, 3'h4);
    chk("kept", {sef, exf}, 2'h1);
    @(posedge clk);
    wake <= 1'b0;
    $display("test sleep done");
    final_report();
  end
endmodule
